// file: verilog/owd_regs.vh
// Constants for the option word decoder: word layout, codes, bus map
`ifndef OWD_REGS_VH
`define OWD_REGS_VH

// ----------------------------------------
// Option word geometry
// ----------------------------------------
`define OWD_WORD_W 13

// ----------------------------------------
// First option word fields
// ----------------------------------------
`define OWD_W0_RSV 12
`define OWD_W0_WIDTH 11
`define OWD_W0_NFDIS 10
`define OWD_W0_RSTPIN 9
`define OWD_W0_IPER_HI 8
`define OWD_W0_IPER_LO 7
`define OWD_W0_WDOG 6
`define OWD_W0_OSC_HI 5
`define OWD_W0_OSC_LO 3
`define OWD_W0_PROT_HI 2
`define OWD_W0_PROT_LO 0

// ----------------------------------------
// Second option word fields
// ----------------------------------------
`define OWD_W1_SRC 12
`define OWD_W1_RSV_LO 11
`define OWD_W1_RSV_HI 10
`define OWD_W1_LP 9
`define OWD_W1_TRIM_HI 8
`define OWD_W1_TRIM_LO 4
`define OWD_W1_FREQ_HI 3
`define OWD_W1_FREQ_LO 2
`define OWD_W1_BOR_HI 1
`define OWD_W1_BOR_LO 0

// ----------------------------------------
// Identification word fields
// ----------------------------------------
`define OWD_W2_SUB_HI 12
`define OWD_W2_SUB_LO 9
`define OWD_W2_RSV8 8
`define OWD_W2_RSV7 7
`define OWD_W2_RSV_HI 6
`define OWD_W2_RSV_LO 5
`define OWD_W2_ID_HI 4
`define OWD_W2_ID_LO 0

// ----------------------------------------
// Oscillator mode codes
// ----------------------------------------
`define OWD_OSC_XTAL 3'h0
`define OWD_OSC_HXTAL 3'h1
`define OWD_OSC_LXTAL 3'h2
`define OWD_OSC_32K 3'h3
`define OWD_OSC_INTRC_IO 3'h4
`define OWD_OSC_INTRC_CLK 3'h5
`define OWD_OSC_EXTRC_IO 3'h6
`define OWD_OSC_EXTRC_CLK 3'h7

// ----------------------------------------
// Internal RC frequency and instruction period codes
// ----------------------------------------
`define OWD_FREQ_4M 2'h0
`define OWD_FREQ_16M 2'h1
`define OWD_FREQ_8M 2'h2
`define OWD_FREQ_UNDEF 2'h3
`define OWD_IPER_4 5'h04
`define OWD_IPER_2 5'h02
`define OWD_IPER_8 5'h08
`define OWD_IPER_16 5'h10

// ----------------------------------------
// Noise filter widths in oscillator periods
// ----------------------------------------
`define OWD_NF_LONG_PERIODS 6'h20
`define OWD_NF_SHORT_PERIODS 6'h08

// ----------------------------------------
// Register map
// ----------------------------------------
`define OWD_CTRL_ADDR 4'h0
`define OWD_STAT_ADDR 4'h4
`define OWD_CTRL_RST 2'h0
`define OWD_CTRL_FREQ_HI 7
`define OWD_CTRL_FREQ_LO 6
`define OWD_RESP_OKAY 2'h0
`define OWD_RESP_SLVERR 2'h2

`endif

// file: verilog/owd_noise_filter.v
// Width filter for the falling-edge external interrupt input
`timescale 1ns/1ps
`include "owd_regs.vh"

module owd_noise_filter (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Synchronised pin level and controls
   input wire int_level,
   input wire filter_on,
   input wire long_width,
   // Accepted falling edge
   output reg int_event
);

   reg prev_reg;
   reg armed_reg;
   reg [5:0] cnt_reg;
   wire [5:0] need_periods;
   wire [5:0] cnt_inc;
   wire fall;

   // One oscillator period is one sys_clk cycle
   assign need_periods = long_width ? `OWD_NF_LONG_PERIODS : `OWD_NF_SHORT_PERIODS;
   assign cnt_inc = cnt_reg + 6'h01;
   assign fall = prev_reg & ~int_level;

   // --------------------------------------
   // Low-pulse width counter
   // --------------------------------------
   // Re-arms only after a high level so a stuck-low pin fires once
   always @(posedge sys_clk) begin
      if (rst) begin
         prev_reg <= 1'b1;
         armed_reg <= 1'b0;
         cnt_reg <= 6'h00;
         int_event <= 1'b0;
      end else begin
         prev_reg <= int_level;
         if (!filter_on) begin
            int_event <= fall;
            cnt_reg <= 6'h00;
            armed_reg <= 1'b0;
         end else if (int_level) begin
            int_event <= 1'b0;
            cnt_reg <= 6'h00;
            armed_reg <= 1'b1;
         end else if (armed_reg) begin
            cnt_reg <= cnt_inc;
            int_event <= (cnt_inc == need_periods);
            if (cnt_inc == need_periods) begin
               armed_reg <= 1'b0;
            end
         end else begin
            int_event <= 1'b0;
         end
      end
   end

endmodule

// file: verilog/owd_decoder.v
// Option word decoder with its control and status register slave
//
// Overview of operation
// - Option words are never mapped on the register bus.
// - Three 13-bit words: two option words and one identification word.
// - Interrupt filter accepts 32-period pulses, or 8 when width bit set.
// - Filter is off in 32 kHz crystal mode or during sleep.
// - First word bit 10 low enables the filter, high disables it.
// - First word bit 9 selects reset input over general I/O.
// - Instruction period code 00/01/10/11 gives 4/2/8/16 clocks.
// - First word bit 6 enables the watchdog.
// - Oscillator codes 000 to 011 select the four crystal modes.
// - Codes 100 to 111 select RC modes with pin use as given.
// - Three-bit protect field set to one enables code protection.
// - Second word bit 12 picks RC frequency from option or register.
// - Second word bit 9 selects low power consumption.
// - RC frequency code 00/01/10 means 4/16/8 MHz.
// - Brown-out code 00 disables; other codes pick the trip level.
// - Third word bits 12 to 9 trim the watchdog sub-oscillator.
// - Third word bits 4 to 0 hold the customer code.
// - Run-time RC frequency comes from control bits 7 and 6.
`timescale 1ns/1ps
`include "owd_regs.vh"

module owd_decoder (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Non-volatile option words
   input wire [12:0] cfg_word0,
   input wire [12:0] cfg_word1,
   input wire [12:0] cfg_word2,
   // External interrupt pin and core state
   input wire int_pin,
   input wire sleep_mode,
   // AXI4-Lite write address
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Interrupt filter result
   output wire ext_int_event,
   output reg filter_active,
   // Decoded core controls
   output reg reset_pin_select,
   output reg [4:0] instr_period_clocks,
   output reg watchdog_on,
   output reg [2:0] code_protect,
   output reg low_power_select,
   // Decoded oscillator controls
   output reg [2:0] osc_mode,
   output reg slow_crystal_32k_mode,
   output reg internal_rc_mode,
   output reg external_rc_mode,
   output reg osc_out_enable,
   output reg osc_out_open_drain,
   output reg rc_input_enable,
   output reg [1:0] rc_freq_sel,
   // Decoded trims, levels and identification
   output reg brownout_enable,
   output reg [1:0] brownout_level,
   output reg [4:0] rc_trim_bits,
   output reg [3:0] sub_osc_trim,
   output reg [4:0] customer_code_bits,
   output reg config_fault
);

   // -----------------------------------------
   // Declarations
   // -----------------------------------------
   reg [12:0] word0_reg;
   reg [12:0] word1_reg;
   reg [12:0] word2_reg;
   reg int_meta_reg;
   reg int_sync_reg;
   reg [1:0] ctrl_freq_reg;
   reg [3:0] aw_addr_reg;
   reg aw_held_reg;
   reg [7:0] w_byte_reg;
   reg w_lane_reg;
   reg w_held_reg;
   reg [2:0] osc_next;
   reg [1:0] freq_next;
   reg [4:0] iper_next;
   reg filter_next;
   reg fault_next;
   reg [31:0] rdata_next;
   reg [1:0] rresp_next;

   // -----------------------------------------
   // Option word capture
   // -----------------------------------------
   // Words are sampled on every clock edge while reset is held and frozen after release
   always @(posedge sys_clk) begin
      if (rst) begin
         word0_reg <= cfg_word0;
         word1_reg <= cfg_word1;
         word2_reg <= cfg_word2;
      end
   end

   // Interrupt pin synchroniser, second stage is the only reader
   always @(posedge sys_clk) begin
      if (rst) begin
         int_meta_reg <= 1'b1;
         int_sync_reg <= 1'b1;
      end else begin
         int_meta_reg <= int_pin;
         int_sync_reg <= int_meta_reg;
      end
   end

   // -----------------------------------------
   // Decode of multi-bit fields
   // -----------------------------------------
   // Oscillator code, instruction period, RC frequency, filter gate
   always @* begin
      osc_next = word0_reg[`OWD_W0_OSC_HI:`OWD_W0_OSC_LO];
      case (word0_reg[`OWD_W0_IPER_HI:`OWD_W0_IPER_LO])
         2'h0: iper_next = `OWD_IPER_4;
         2'h1: iper_next = `OWD_IPER_2;
         2'h2: iper_next = `OWD_IPER_8;
         default: iper_next = `OWD_IPER_16;
      endcase
      if (word1_reg[`OWD_W1_SRC]) begin
         freq_next = ctrl_freq_reg;
      end else begin
         freq_next = word1_reg[`OWD_W1_FREQ_HI:`OWD_W1_FREQ_LO];
      end
      if (freq_next == `OWD_FREQ_UNDEF) begin
         freq_next = `OWD_FREQ_4M;
      end
      filter_next = !word0_reg[`OWD_W0_NFDIS]
         && (osc_next != `OWD_OSC_32K) && !sleep_mode;
      fault_next = (word1_reg[`OWD_W1_TRIM_HI:`OWD_W1_TRIM_LO] != 5'h00)
         || word0_reg[`OWD_W0_RSV] || word1_reg[`OWD_W1_RSV_LO]
         || !word1_reg[`OWD_W1_RSV_HI]
         || word2_reg[`OWD_W2_RSV8] || !word2_reg[`OWD_W2_RSV7]
         || (word2_reg[`OWD_W2_RSV_HI:`OWD_W2_RSV_LO] != 2'h0);
   end

   // -----------------------------------------
   // Registered control outputs
   // -----------------------------------------
   // Outputs show safe defaults while reset is held
   always @(posedge sys_clk) begin
      if (rst) begin
         filter_active <= 1'b0;
         reset_pin_select <= 1'b0;
         instr_period_clocks <= `OWD_IPER_4;
         watchdog_on <= 1'b0;
         code_protect <= 3'h0;
         low_power_select <= 1'b0;
         osc_mode <= `OWD_OSC_XTAL;
         slow_crystal_32k_mode <= 1'b0;
         internal_rc_mode <= 1'b0;
         external_rc_mode <= 1'b0;
         osc_out_enable <= 1'b0;
         osc_out_open_drain <= 1'b0;
         rc_input_enable <= 1'b0;
         rc_freq_sel <= `OWD_FREQ_4M;
         brownout_enable <= 1'b0;
         brownout_level <= 2'h0;
         rc_trim_bits <= 5'h00;
         sub_osc_trim <= 4'h0;
         customer_code_bits <= 5'h00;
         config_fault <= 1'b0;
      end else begin
         filter_active <= filter_next;
         reset_pin_select <= word0_reg[`OWD_W0_RSTPIN];
         instr_period_clocks <= iper_next;
         watchdog_on <= word0_reg[`OWD_W0_WDOG];
         code_protect <= word0_reg[`OWD_W0_PROT_HI:`OWD_W0_PROT_LO];
         low_power_select <= word1_reg[`OWD_W1_LP];
         osc_mode <= osc_next;
         slow_crystal_32k_mode <= (osc_next == `OWD_OSC_32K);
         internal_rc_mode <= (osc_next == `OWD_OSC_INTRC_IO)
            || (osc_next == `OWD_OSC_INTRC_CLK);
         external_rc_mode <= (osc_next == `OWD_OSC_EXTRC_IO)
            || (osc_next == `OWD_OSC_EXTRC_CLK);
         osc_out_enable <= (osc_next == `OWD_OSC_INTRC_CLK)
            || (osc_next == `OWD_OSC_EXTRC_CLK);
         osc_out_open_drain <= (osc_next == `OWD_OSC_EXTRC_CLK);
         rc_input_enable <= (osc_next == `OWD_OSC_EXTRC_IO)
            || (osc_next == `OWD_OSC_EXTRC_CLK);
         rc_freq_sel <= freq_next;
         brownout_enable <= (word1_reg[`OWD_W1_BOR_HI:`OWD_W1_BOR_LO] != 2'h0);
         brownout_level <= word1_reg[`OWD_W1_BOR_HI:`OWD_W1_BOR_LO];
         rc_trim_bits <= word1_reg[`OWD_W1_TRIM_HI:`OWD_W1_TRIM_LO];
         sub_osc_trim <= word2_reg[`OWD_W2_SUB_HI:`OWD_W2_SUB_LO];
         customer_code_bits <= word2_reg[`OWD_W2_ID_HI:`OWD_W2_ID_LO];
         config_fault <= fault_next;
      end
   end

   // -----------------------------------------
   // External interrupt width filter
   // -----------------------------------------
   owd_noise_filter u_filter (
      .sys_clk(sys_clk),
      .rst(rst),
      .int_level(int_sync_reg),
      .filter_on(filter_active),
      .long_width(!word0_reg[`OWD_W0_WIDTH]),
      .int_event(ext_int_event)
   );

   // -----------------------------------------
   // AXI4-Lite write channel
   // -----------------------------------------
   // Address and data are taken in either order, then answered
   always @(posedge sys_clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OWD_RESP_OKAY;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_byte_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         ctrl_freq_reg <= `OWD_CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (!aw_held_reg && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (!w_held_reg && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg == `OWD_CTRL_ADDR) begin
               s_axi_bresp <= `OWD_RESP_OKAY;
               if (w_lane_reg) begin
                  ctrl_freq_reg <= w_byte_reg[`OWD_CTRL_FREQ_HI:`OWD_CTRL_FREQ_LO];
               end
            end else if (aw_addr_reg == `OWD_STAT_ADDR) begin
               s_axi_bresp <= `OWD_RESP_OKAY;
            end else begin
               s_axi_bresp <= `OWD_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------
   // AXI4-Lite read channel
   // -----------------------------------------
   // Only control and status are visible; option words stay hidden
   always @* begin
      rdata_next = 32'h00000000;
      rresp_next = `OWD_RESP_OKAY;
      if (s_axi_araddr == `OWD_CTRL_ADDR) begin
         rdata_next[`OWD_CTRL_FREQ_HI:`OWD_CTRL_FREQ_LO] = ctrl_freq_reg;
      end else if (s_axi_araddr == `OWD_STAT_ADDR) begin
         rdata_next[3:0] = {config_fault, filter_active, rc_freq_sel};
      end else begin
         rresp_next = `OWD_RESP_SLVERR;
      end
   end

   // Read answer one cycle after the address is taken
   always @(posedge sys_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `OWD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_next;
         s_axi_rresp <= rresp_next;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// file: verif/owd_decoder_properties.sv
// Concurrent checks on the decoded outputs of the option word decoder
`timescale 1ns/1ps
module owd_decoder_properties (
   // Clock, reset and inputs
   input wire sys_clk,
   input wire rst,
   input wire [12:0] cfg_word0,
   input wire [12:0] cfg_word1,
   input wire [12:0] cfg_word2,
   input wire int_pin,
   input wire sleep_mode,
   // Interrupt filter
   input wire ext_int_event,
   input wire filter_active,
   // Decoded controls
   input wire reset_pin_select,
   input wire [4:0] instr_period_clocks,
   input wire watchdog_on,
   input wire [2:0] code_protect,
   input wire low_power_select,
   input wire [2:0] osc_mode,
   input wire slow_crystal_32k_mode,
   input wire internal_rc_mode,
   input wire external_rc_mode,
   input wire osc_out_enable,
   input wire osc_out_open_drain,
   input wire rc_input_enable,
   input wire [1:0] rc_freq_sel,
   input wire brownout_enable,
   input wire [1:0] brownout_level,
   input wire [4:0] rc_trim_bits,
   input wire [3:0] sub_osc_trim,
   input wire [4:0] customer_code_bits
);
   reg [12:0] cap0_reg;
   reg [12:0] cap1_reg;
   reg [12:0] cap2_reg;
   reg [1:0] run_reg;
   // Shadow copy of the words taken in reset, and a settle counter
   always @(posedge sys_clk) begin
      if (rst) begin
         cap0_reg <= cfg_word0;
         cap1_reg <= cfg_word1;
         cap2_reg <= cfg_word2;
         run_reg <= 2'h0;
      end else if (run_reg != 2'h3) begin
         run_reg <= run_reg + 2'h1;
      end
   end
   // Expected decodes
   wire settled = run_reg == 2'h3;
   wire [2:0] oc = cap0_reg[5:3];
   wire [5:0] osc_exp = {oc == 3'h3, oc[2:1] == 2'h2, oc[2:1] == 2'h3, oc[2] & oc[0],
      oc == 3'h7, oc[2:1] == 2'h3};
   wire [5:0] osc_got = {slow_crystal_32k_mode, internal_rc_mode, external_rc_mode,
      osc_out_enable, osc_out_open_drain, rc_input_enable};
   wire [1:0] pc = cap0_reg[8:7];
   wire [4:0] iper_exp = pc == 2'h0 ? 5'h04 : pc == 2'h1 ? 5'h02 : pc == 2'h2 ? 5'h08 : 5'h10;
   wire [5:0] core_exp = {cap0_reg[9], cap0_reg[6], cap0_reg[2:0], cap1_reg[9]};
   wire [5:0] core_got = {reset_pin_select, watchdog_on, code_protect, low_power_select};
   wire [1:0] fopt = cap1_reg[3:2] == 2'h3 ? 2'h0 : cap1_reg[3:2];
   wire cfg_off = cap0_reg[10] || oc == 3'h3;
   wire [19:0] decoded = {reset_pin_select, instr_period_clocks, watchdog_on, code_protect,
      osc_mode, brownout_level, customer_code_bits};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Falling pin edges with the filter bypassed or in use
   sequence s_unfiltered_fall;
      settled && !filter_active && $fell(int_pin);
   endsequence
   sequence s_filtered_fall;
      settled && filter_active && $fell(int_pin);
   endsequence
   chk_words_hold: assert property (settled |-> $stable(decoded))
      else $error("decoded outputs moved after reset");
   chk_period_map: assert property (settled |-> instr_period_clocks == iper_exp)
      else $error("instruction period wrong");
   chk_core_bits: assert property (settled |-> core_got == core_exp)
      else $error("core control bits wrong");
   chk_osc_decode: assert property (settled |->
      osc_mode == oc && osc_got == osc_exp)
      else $error("oscillator decode wrong");
   chk_rc_freq: assert property (settled |->
      rc_freq_sel != 2'h3 && (cap1_reg[12] || rc_freq_sel == fopt))
      else $error("rc frequency code wrong");
   chk_brownout_map: assert property (settled |->
      brownout_enable == (cap1_reg[1:0] != 2'h0) && brownout_level == cap1_reg[1:0])
      else $error("brownout decode wrong");
   chk_trim_fields: assert property (settled |->
      {sub_osc_trim, customer_code_bits, rc_trim_bits} ==
      {cap2_reg[12:9], cap2_reg[4:0], cap1_reg[8:4]})
      else $error("trim or id fields wrong");
   chk_filter_state: assert property (settled |->
      filter_active == !($past(sleep_mode) || cfg_off))
      else $error("filter enable state wrong");
   chk_bypass_edge: assert property (s_unfiltered_fall |-> ##3 ext_int_event)
      else $error("unfiltered edge not passed");
   chk_short_reject: assert property (s_filtered_fall |-> ##1 !ext_int_event [*8])
      else $error("filtered edge passed too early");
   chk_event_pulse: assert property (ext_int_event |=> !ext_int_event)
      else $error("event longer than one cycle");
endmodule

bind owd_decoder owd_decoder_properties u_chk (.*);

// file: verif/tb.sv
// Self-checking bench for the option word decoder
`timescale 1ns/1ps
module tb;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   reg sys_clk, rst, int_pin, sleep_mode;
   reg [12:0] cfg_word0, cfg_word1, cfg_word2;
   reg [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   reg [31:0] s_axi_wdata;
   reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, rc_freq_sel, brownout_level;
   wire [31:0] s_axi_rdata;
   wire ext_int_event, filter_active, reset_pin_select, watchdog_on, low_power_select;
   wire slow_crystal_32k_mode, internal_rc_mode, external_rc_mode, osc_out_enable;
   wire osc_out_open_drain, rc_input_enable, brownout_enable, config_fault;
   wire [4:0] instr_period_clocks, rc_trim_bits, customer_code_bits;
   wire [2:0] code_protect, osc_mode;
   wire [3:0] sub_osc_trim;
   integer fail_count, check_count, n, cnt, lat, lat32;
   reg [31:0] rd;
   reg [1:0] rsp;

   owd_decoder u_dut (.*);

   // Clock of 40 ns
   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task check(input [31:0] got, input [31:0] exp, input [8*8:1] what);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t %0s got %0h exp %0h", $time, what, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Words are only taken while reset is high
   task do_reset(input [12:0] a, input [12:0] b, input [12:0] c);
      begin
         cfg_word0 <= a;
         cfg_word1 <= b;
         cfg_word2 <= c;
         rst <= 1'h1;
         repeat (3) @(posedge sys_clk);
         rst <= 1'h0;
         repeat (3) @(posedge sys_clk);
      end
   endtask
   task axi_write(input [3:0] a, input [31:0] d);
      integer k;
      reg got;
      begin
         got = 1'h0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         for (k = 0; k < 40 && !got; k = k + 1) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
               got = 1'h1;
               rsp = s_axi_bresp;
               s_axi_bready <= 1'h0;
            end
         end
         check(got, 1, "bvalid");
         @(posedge sys_clk);
      end
   endtask
   task axi_read(input [3:0] a);
      integer k;
      reg got;
      begin
         got = 1'h0;
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         for (k = 0; k < 40 && !got; k = k + 1) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
               got = 1'h1;
               rd = s_axi_rdata;
               rsp = s_axi_rresp;
               s_axi_rready <= 1'h0;
            end
         end
         check(got, 1, "rvalid");
         @(posedge sys_clk);
      end
   endtask
   // Pin low for len cycles; counts events and first latency
   task pulse(input integer len);
      integer k;
      begin
         cnt = 0;
         lat = 0;
         int_pin <= 1'h0;
         for (k = 1; k < len + 45; k = k + 1) begin
            @(posedge sys_clk);
            if (k == len) int_pin <= 1'h1;
            if (ext_int_event === 1'h1) begin
               cnt = cnt + 1;
               if (lat == 0) lat = k;
            end
         end
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_decode;
      reg [2:0] i;
      reg [4:0] ip;
      begin
         for (n = 0; n < 8; n = n + 1) begin
            i = n;
            ip = i[1:0] == 2'h0 ? 5'h04 : i[1:0] == 2'h1 ? 5'h02 : i[1:0] == 2'h2 ? 5'h08 : 5'h10;
            do_reset({1'h0, i[0], 1'h0, i[1], i[1:0], i[2], i, ~i},
               {3'h1, i[0], 5'h00, i[2:1], i[1:0]}, {i, ~i[0], 4'h4, ~i, i[1:0]});
            check(osc_mode, i, "osc");
            check({slow_crystal_32k_mode, internal_rc_mode, external_rc_mode, osc_out_enable,
               osc_out_open_drain, rc_input_enable}, {i == 3'h3, i[2:1] == 2'h2,
               i[2:1] == 2'h3, i[2] & i[0], i == 3'h7, i[2:1] == 2'h3}, "pins");
            check(instr_period_clocks, ip, "period");
            check({reset_pin_select, watchdog_on, code_protect, low_power_select},
               {i[1], i[2], ~i, i[0]}, "core");
            check(rc_freq_sel, (i[2:1] == 2'h3) ? 2'h0 : i[2:1], "freq");
            check({brownout_enable, brownout_level}, {i[1:0] != 2'h0, i[1:0]}, "bor");
            check({sub_osc_trim, customer_code_bits, rc_trim_bits},
               {i, ~i[0], ~i, i[1:0], 5'h00}, "ids");
            check(config_fault, 0, "fault");
         end
         cfg_word0 <= 13'h0000;
         repeat (4) @(posedge sys_clk);
         check({osc_mode, instr_period_clocks}, {3'h7, 5'h10}, "hold");
         do_reset(13'h1000, 13'h0400, 13'h0080);
         check(config_fault, 1, "fault0");
         do_reset(13'h0000, 13'h0410, 13'h0080);
         check(config_fault, 1, "trim");
         do_reset(13'h0000, 13'h0400, 13'h0000);
         check(config_fault, 1, "fault2");
      end
   endtask
   task t_filter;
      begin
         do_reset(13'h0000, 13'h0400, 13'h0080);
         check(filter_active, 1, "fon");
         pulse(31);
         check(cnt, 0, "n31");
         pulse(32);
         check(cnt, 1, "n32");
         lat32 = lat;
         do_reset(13'h0800, 13'h0400, 13'h0080);
         pulse(7);
         check(cnt, 0, "n7");
         pulse(50);
         check(cnt, 1, "n50");
         check(lat32 - lat, 24, "lat");
         sleep_mode <= 1'h1;
         repeat (2) @(posedge sys_clk);
         check(filter_active, 0, "sleep");
         pulse(1);
         check(cnt, 1, "slp1");
         sleep_mode <= 1'h0;
         do_reset(13'h0400, 13'h0400, 13'h0080);
         check(filter_active, 0, "fdis");
         pulse(1);
         check(cnt, 1, "dis1");
         do_reset(13'h0018, 13'h0400, 13'h0080);
         pulse(1);
         check(cnt, 1, "k32");
      end
   endtask
   task t_regs;
      reg [1:0] c;
      begin
         do_reset(13'h0000, 13'h1400, 13'h0080);
         for (n = 0; n < 4; n = n + 1) begin
            c = n;
            axi_write(4'h0, {24'h0, c, 6'h00});
            check(rsp, 0, "wr");
            check(rc_freq_sel, (c == 2'h3) ? 2'h0 : c, "rtfreq");
            axi_read(4'h0);
            check(rd, {24'h0, c, 6'h00}, "ctrl");
            axi_read(4'h4);
            check(rd, {29'h0, 1'h1, (c == 2'h3) ? 2'h0 : c}, "status");
         end
         // Write with the low lane disabled must leave the control bits alone
         s_axi_wstrb <= 4'hE;
         axi_write(4'h0, 32'h00000040);
         s_axi_wstrb <= 4'hF;
         check(rsp, 0, "nolnwr");
         axi_read(4'h0);
         check(rd, 32'h000000C0, "nolane");
         for (n = 8; n < 16; n = n + 4) begin
            axi_read(n[3:0]);
            check(rsp, 2, "unmrd");
            check(rd, 0, "unmdata");
            axi_write(n[3:0], 32'hFFFFFFFF);
            check(rsp, 2, "unmwr");
         end
         do_reset(13'h0000, 13'h0404, 13'h0080);
         axi_write(4'h0, 32'h00000080);
         check(rc_freq_sel, 1, "optsrc");
      end
   endtask
   // Hang guard
   initial begin
      #400000;
      fail_count = fail_count + 1;
      final_report;
   end
   // Main sequence
   initial begin
      fail_count = 0;
      check_count = 0;
      rst = 1'h1;
      int_pin = 1'h1;
      sleep_mode = 1'h0;
      cfg_word0 = 13'h0000;
      cfg_word1 = 13'h0400;
      cfg_word2 = 13'h0080;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wdata = 32'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (6) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      t_decode;
      t_filter;
      t_regs;
      final_report;
   end
endmodule
